// File: verilog/plm_macrocell.sv
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "plm_map.svh"
module plm_macrocell (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// device pins
	input  wire logic        dev_clk_pin,
	input  wire logic        dev_oe_n_pin,
	input  wire logic [7:0]  in_pin,
	input  wire logic [7:0]  io_in,
	output logic [7:0]       io_out,
	output logic [7:0]       io_oe_n,
	// power state
	output logic             standby
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic plm_pkg::plm_cell_e cell_kind(input logic emu, input logic md);
		if (emu && md) begin
			cell_kind = plm_pkg::CELL_CIO;
		end else if (emu) begin
			cell_kind = plm_pkg::CELL_REG;
		end else if (md) begin
			cell_kind = plm_pkg::CELL_DIN;
		end else begin
			cell_kind = plm_pkg::CELL_COUT;
		end
	endfunction : cell_kind

	function automatic logic cfg_legal(input plm_pkg::plm_cfg_s c);
		cfg_legal = 1'b1;
		if (!c.rag && !c.emu) begin
			cfg_legal = 1'b0;
		end else if (c.rag && c.emu && (c.mode != 8'hFF)) begin
			cfg_legal = 1'b0;
		end else if (c.rag && !c.emu) begin
			cfg_legal = !(c.mode[`PLM_CENTER_A] || c.mode[`PLM_CENTER_B]);
		end
	endfunction : cfg_legal

	// unprogrammed term reads high, but the zero-power part cuts it off
	function automatic logic pterm(input logic [31:0] mask, input logic [31:0] lit,
			input logic zp);
		if (mask == 32'h0000_0000) begin
			pterm = !zp;
		end else begin
			pterm = ((mask & lit) == mask);
		end
	endfunction : pterm

	// ----------------------------------------
	// state
	// ----------------------------------------
	plm_pkg::plm_pins_s pins_raw;
	plm_pkg::plm_pins_s pin_s1;
	plm_pkg::plm_pins_s pin_s2;
	plm_pkg::plm_pins_s pin_s3;
	plm_pkg::plm_pins_s pin_f;
	plm_pkg::plm_pins_s next_pin_f;
	plm_pkg::plm_cfg_s  cfg;
	plm_pkg::plm_pwr_e  pwr;
	plm_pkg::plm_cell_e kind [8];
	logic [31:0]        arr [64];
	logic [63:0]        pt;
	logic [63:0]        sig;
	logic [7:0]         q;
	logic [7:0]         next_q;
	logic [7:0]         next_out;
	logic [7:0]         next_oe_n;
	logic [7:0]         cell_f;
	logic [7:0]         cell_sum;
	logic [7:0]         fb;
	logic [2:0]         quiet_cnt;
	logic               run;
	logic               zp;
	logic               frc;
	logic               secured;
	logic               err;
	logic               wr_ok;
	logic               rd_setup;
	logic               is_arr;
	logic               clk_rise;
	logic               wake;
	logic               hold;
	logic               preload_wr;
	logic               erase_wr;
	logic [31:0]        rd_val;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pins_raw = '{clk: dev_clk_pin, oe_n: dev_oe_n_pin, io: io_in, in: in_pin};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_f  <= '0;
		end else begin
			pin_s1 <= pins_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= next_pin_f;
		end
	end

	// a bit moves only once the second and third stages agree
	assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
	assign clk_rise   = next_pin_f.clk & ~pin_f.clk;

	// ----------------------------------------
	// zero-power standby
	// ----------------------------------------
	always_comb begin
		wake = |((next_pin_f ^ pin_f) & 18'h1_FFFF);
		if (!frc) begin
			wake = wake | (next_pin_f.clk ^ pin_f.clk);
		end
	end

	// wake is combinational so the first changed cycle already updates outputs
	assign hold    = (pwr == plm_pkg::PWR_STANDBY) && !wake;
	assign standby = (pwr == plm_pkg::PWR_STANDBY);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr       <= plm_pkg::PWR_ACTIVE;
			quiet_cnt <= 3'h0;
		end else begin
			unique case (pwr)
				plm_pkg::PWR_ACTIVE: begin
					if (wake || !zp) begin
						quiet_cnt <= 3'h0;
					end else if (quiet_cnt == 3'(`PLM_QUIET_CYC - 1)) begin
						pwr       <= plm_pkg::PWR_STANDBY;
						quiet_cnt <= 3'h0;
					end else begin
						quiet_cnt <= quiet_cnt + 3'h1;
					end
				end
				plm_pkg::PWR_STANDBY: begin
					if (wake || !zp) begin
						pwr <= plm_pkg::PWR_ACTIVE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// sum of products and cell muxes
	// ----------------------------------------
	always_comb begin
		logic [15:0] ai;
		logic [31:0] lit;
		logic        s;
		ai        = '0;
		lit       = '0;
		s         = 1'b0;
		next_out  = io_out;
		next_oe_n = io_oe_n;
		next_q    = q;
		pt        = '0;
		cell_f    = '0;
		cell_sum  = '0;
		for (int c = 0; c < 8; c++) begin
			kind[c] = cell_kind(cfg.emu, cfg.mode[c]);
			if (kind[c] == plm_pkg::CELL_REG) begin
				fb[c] = ~q[c];
			end else if (kind[c] == plm_pkg::CELL_COUT
					&& (c == `PLM_CENTER_A || c == `PLM_CENTER_B)) begin
				fb[c] = 1'b0;
			end else begin
				fb[c] = pin_f.io[c];
			end
		end
		ai  = {fb, pin_f.in};
		lit = {~ai, ai};
		for (int t = 0; t < 64; t++) begin
			pt[t] = pterm(arr[t], lit, zp);
		end
		for (int c = 0; c < 8; c++) begin
			s = |pt[c*8 +: 7];
			if (kind[c] != plm_pkg::CELL_CIO) begin
				s = s | pt[c*8 + 7];
			end
			cell_sum[c] = s;
			cell_f[c]   = s ^ ~cfg.pol[c];
			unique case (kind[c])
				plm_pkg::CELL_REG: begin
					next_out[c]  = ~q[c];
					next_oe_n[c] = pin_f.oe_n;
					if (clk_rise) begin
						next_q[c] = ~cell_f[c];
					end
				end
				plm_pkg::CELL_CIO: begin
					next_out[c]  = cell_f[c];
					next_oe_n[c] = ~pt[c*8 + 7];
				end
				plm_pkg::CELL_COUT: begin
					next_out[c]  = cell_f[c];
					next_oe_n[c] = 1'b0;
				end
				plm_pkg::CELL_DIN: begin
					next_out[c]  = 1'b0;
					next_oe_n[c] = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// macrocell flip-flops and pin drivers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 8'h00;
		end else if (preload_wr) begin
			q <= ~pin_f.io;
		end else if (!hold) begin
			q <= next_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_out  <= 8'h00;
			io_oe_n <= 8'hFF;
		end else if (!hold) begin
			io_out  <= next_out;
			io_oe_n <= next_oe_n;
		end
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign pready   = 1'b1;
	assign is_arr   = (paddr[11:8] == `PLM_ARRAY_PAGE);
	assign rd_setup = psel && !penable && !pwrite;

	always_comb begin
		err = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			err = 1'b1;
		end else if (is_arr) begin
			err = pwrite && (secured || run);
		end else begin
			case (paddr)
				`PLM_ADDR_CONFIG: err = pwrite && (run || !cfg_legal(pwdata));
				`PLM_ADDR_CTRL:   err = pwrite && run && pwdata[`PLM_CTRL_ERASE];
				`PLM_ADDR_STATUS: err = pwrite;
				`PLM_ADDR_SIG_LO: err = pwrite && secured;
				`PLM_ADDR_SIG_HI: err = pwrite && secured;
				default:          err = 1'b1;
			endcase
		end
	end

	assign pslverr    = psel && penable && err;
	assign wr_ok      = psel && penable && pwrite && !err;
	assign preload_wr = wr_ok && (paddr == `PLM_ADDR_CTRL) && pwdata[`PLM_CTRL_PRELOAD];
	assign erase_wr   = wr_ok && (paddr == `PLM_ADDR_CTRL) && pwdata[`PLM_CTRL_ERASE];

	// ----------------------------------------
	// configuration, array and security
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= `PLM_CONFIG_RESET;
		end else if (erase_wr) begin
			cfg <= `PLM_CONFIG_RESET;
		end else if (wr_ok && !is_arr && paddr == `PLM_ADDR_CONFIG) begin
			cfg <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < 64; t++) begin
				arr[t] <= 32'h0000_0000;
			end
		end else if (erase_wr) begin
			for (int t = 0; t < 64; t++) begin
				arr[t] <= 32'h0000_0000;
			end
		end else if (wr_ok && is_arr) begin
			arr[paddr[7:2]] <= pwdata;
		end
	end

	// secure is a one-way latch; the erase that wipes the array is its only way back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secured <= 1'b0;
		end else if (erase_wr) begin
			secured <= 1'b0;
		end else if (wr_ok && paddr == `PLM_ADDR_CTRL && pwdata[`PLM_CTRL_SECURE]) begin
			secured <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run <= 1'b0;
			zp  <= 1'b0;
			frc <= 1'b0;
		end else if (wr_ok && !is_arr && paddr == `PLM_ADDR_CTRL) begin
			run <= pwdata[`PLM_CTRL_RUN];
			zp  <= pwdata[`PLM_CTRL_ZP];
			frc <= pwdata[`PLM_CTRL_FRC];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig <= 64'h0000_0000_0000_0000;
		end else if (wr_ok && !is_arr && paddr == `PLM_ADDR_SIG_LO) begin
			sig[31:0] <= pwdata;
		end else if (wr_ok && !is_arr && paddr == `PLM_ADDR_SIG_HI) begin
			sig[63:32] <= pwdata;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		if (is_arr) begin
			rd_val = secured ? 32'h0000_0000 : arr[paddr[7:2]];
		end else begin
			case (paddr)
				`PLM_ADDR_CONFIG: rd_val = cfg;
				`PLM_ADDR_CTRL:   rd_val = {26'h0, frc, zp, 3'h0, run};
				`PLM_ADDR_STATUS: rd_val = {16'h0, q, 6'h0, standby, secured};
				`PLM_ADDR_SIG_LO: rd_val = sig[31:0];
				`PLM_ADDR_SIG_HI: rd_val = sig[63:32];
				default:          rd_val = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_val;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_reg_load;
		kind[0] == plm_pkg::CELL_REG && clk_rise && !hold && !preload_wr
			|=> q[0] == ~$past(cell_f[0]) ##1 io_out[0] == $past(cell_f[0], 2);
	endproperty
	a_reg_load: assert property (p_reg_load) else $error("registered cell load wrong");

	property p_cio_enable;
		kind[1] == plm_pkg::CELL_CIO && !hold |=> io_oe_n[1] == ~$past(pt[15]);
	endproperty
	a_cio_enable: assert property (p_cio_enable) else $error("cio enable wrong");

	property p_din_off;
		kind[2] == plm_pkg::CELL_DIN && !hold |=> io_oe_n[2];
	endproperty
	a_din_off: assert property (p_din_off) else $error("input cell driving");

	property p_polarity;
		kind[5] == plm_pkg::CELL_COUT && !hold
			|=> !io_oe_n[5] && io_out[5] == ($past(cell_sum[5]) ~^ $past(cfg.pol[5]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("output polarity wrong");

	property p_center;
		kind[3] != plm_pkg::CELL_DIN && kind[4] != plm_pkg::CELL_DIN;
	endproperty
	a_center: assert property (p_center) else $error("centre cell as input");

	property p_preload;
		preload_wr |=> q == ~$past(pin_f.io);
	endproperty
	a_preload: assert property (p_preload) else $error("preload lost");

	property p_no_readback;
		secured && rd_setup && is_arr |=> prdata == 32'h0000_0000;
	endproperty
	a_no_readback: assert property (p_no_readback) else $error("pattern leaked");

	property p_no_program;
		secured && psel && penable && pwrite && is_arr |-> pslverr;
	endproperty
	a_no_program: assert property (p_no_program) else $error("secured write taken");

	property p_secure_clear;
		$fell(secured) |-> $past(erase_wr);
	endproperty
	a_secure_clear: assert property (p_secure_clear) else $error("security cleared alone");

	property p_standby_entry;
		$rose(standby) |-> $past(quiet_cnt) == 3'(`PLM_QUIET_CYC - 1) && $past(zp);
	endproperty
	a_standby_entry: assert property (p_standby_entry) else $error("early standby");

	property p_hold;
		hold && !preload_wr |=> $stable(io_out) && $stable(io_oe_n) && $stable(q);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved in standby");

	property p_cfg_static;
		run && !erase_wr |=> $stable(cfg);
	endproperty
	a_cfg_static: assert property (p_cfg_static) else $error("config changed running");

endmodule : plm_macrocell

// File: include/plm_map.svh
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH
// What this block does
// - registered cell loads flip-flop on clock rise
// - combinatorial I/O: seven terms, eighth enables
// - dedicated input cell keeps buffer disabled
// - combinatorial output cell uses all eight terms
// - polarity applied by xor after sum
// - polarity one active high, zero active low
// - no dedicated input on centre cells
// - flip-flops clear low at power-up
// - registered pins show high after power-up
// - combinatorial pins show logic after power-up
// - tester preloads any state through pins
// - preload still works when secured
// - secured device refuses pattern readback
// - secured device refuses programming
// - security cleared only by full erase
// - 64-bit user signature memory
// - signature readable regardless of security
// - quiet inputs enter standby after 50 ns
// - outputs hold levels during standby
// - any input change wakes the device, the clock pin only while frc is clear
// - waking adds no output delay
// - free-running clock alone does not wake
// - unused terms disabled in zero-power variant

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PLM_ADDR_CONFIG   12'h000
`define PLM_ADDR_CTRL     12'h004
`define PLM_ADDR_STATUS   12'h008
`define PLM_ADDR_SIG_LO   12'h010
`define PLM_ADDR_SIG_HI   12'h014
`define PLM_ARRAY_PAGE    4'h1

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PLM_CTRL_RUN      0
`define PLM_CTRL_PRELOAD  1
`define PLM_CTRL_ERASE    2
`define PLM_CTRL_SECURE   3
`define PLM_CTRL_ZP       4
`define PLM_CTRL_FRC      5
`define PLM_CONFIG_RESET  32'h00FF_0001
`define PLM_CENTER_A      3
`define PLM_CENTER_B      4

// ----------------------------------------
// timing
// ----------------------------------------
`define PLM_CLK_NS        10
`define PLM_QUIET_NS      50
`define PLM_QUIET_CYC     ((`PLM_QUIET_NS + `PLM_CLK_NS - 1) / `PLM_CLK_NS)
`endif

// File: include/plm_pkg.sv
package plm_pkg;
	typedef struct packed {
		logic       clk;
		logic       oe_n;
		logic [7:0] io;
		logic [7:0] in;
	} plm_pins_s;

	typedef struct packed {
		logic [7:0] resv;
		logic [7:0] pol;
		logic [7:0] mode;
		logic [5:0] pad;
		logic       emu;
		logic       rag;
	} plm_cfg_s;

	typedef enum logic [1:0] {
		CELL_REG  = 2'b00,
		CELL_CIO  = 2'b01,
		CELL_COUT = 2'b10,
		CELL_DIN  = 2'b11
	} plm_cell_e;

	typedef enum logic {
		PWR_ACTIVE  = 1'b0,
		PWR_STANDBY = 1'b1
	} plm_pwr_e;
endpackage : plm_pkg

// File: verif/plm_board.sv
`timescale 1ns/1ns
// ----------------------------------------
// board side of the eight cell pins
// ----------------------------------------
module plm_board (
	// device side
	input  wire logic [7:0] io_out,
	input  wire logic [7:0] io_oe_n,
	// tester drive
	input  wire logic [7:0] drv_val,
	input  wire logic [7:0] drv_en,
	// resolved pin level
	output logic [7:0]      io_in
);
	// pull-up on each pin: a released pin reads high, never its last driven value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!io_oe_n[i])
				io_in[i] = io_out[i];
			else if (drv_en[i])
				io_in[i] = drv_val[i];
			else
				io_in[i] = 1'b1;
		end
	end
endmodule : plm_board

// File: verif/plm_macrocell_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module plm_macrocell_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        dev_clk_pin;
	logic        dev_oe_n_pin;
	logic [7:0]  in_pin;
	logic [7:0]  io_in;
	logic [7:0]  io_out;
	logic [7:0]  io_oe_n;
	logic        standby;
	logic [7:0]  drv_val;
	logic [7:0]  drv_en;
	int          mismatches;
	int          checks_done;

	plm_macrocell dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .dev_clk_pin(dev_clk_pin),
		.dev_oe_n_pin(dev_oe_n_pin), .in_pin(in_pin), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .standby(standby)
	);
	plm_board brd (
		.io_out(io_out), .io_oe_n(io_oe_n), .drv_val(drv_val), .drv_en(drv_en),
		.io_in(io_in)
	);

	always #5 pclk = ~pclk;

	// ----------------------------------------
	// bus and timing helpers
	// ----------------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			report_and_stop;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d, input logic x);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		`CHK("pslverr", x, e);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		`CHK("prdata", x, r & m);
	endtask : rd

	// pin changes pass a three-stage synchroniser, so give them six edges
	task st(input int k);
		repeat (k) @(posedge pclk);
	endtask : st

	task sw;
		int n;
		n = 0;
		while (standby !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
	endtask : sw

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		st(6);
		`CHK("io_oe_n", 8'h00, io_oe_n);
		`CHK("io_out", 8'hFF, io_out);
		rd(12'h000, 32'hFFFF_FFFF, 32'h00FF_0001);
		rd(12'h008, 32'h0000_FF01, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	task t_pol;
		wr(12'h000, 32'h0000_0001, 1'b0);
		wr(12'h004, 32'h0000_0001, 1'b0);
		st(6);
		`CHK("io_out", 8'h00, io_out);
		wr(12'h000, 32'h00FF_0001, 1'b1);
		wr(12'h004, 32'h0000_0000, 1'b0);
		wr(12'h000, 32'h000F_0001, 1'b0);
		wr(12'h004, 32'h0000_0001, 1'b0);
		st(6);
		`CHK("io_out", 8'h0F, io_out);
		wr(12'h004, 32'h0000_0000, 1'b0);
		wr(12'h000, 32'h00FF_0001, 1'b0);
		wr(12'h100, 32'h0000_0001, 1'b0);
		wr(12'h004, 32'h0000_0011, 1'b0);
		in_pin <= 8'h01;
		st(6);
		`CHK("io_out", 8'h01, io_out);
		in_pin <= 8'h00;
		st(6);
		`CHK("io_out", 8'h00, io_out);
		$display("test polarity done");
	endtask : t_pol

	task t_reg;
		wr(12'h004, 32'h0000_0000, 1'b0);
		wr(12'h000, 32'h00FF_0002, 1'b0);
		wr(12'h120, 32'h0000_0002, 1'b0);
		wr(12'h004, 32'h0000_0011, 1'b0);
		st(6);
		`CHK("io_out", 8'hFF, io_out);
		`CHK("io_oe_n", 8'h00, io_oe_n);
		rd(12'h008, 32'h0000_FF00, 32'h0000_0000);
		in_pin <= 8'h01;
		st(6);
		`CHK("io_out", 8'hFF, io_out);
		dev_clk_pin <= 1'b1;
		st(6);
		`CHK("io_out", 8'h01, io_out);
		rd(12'h008, 32'h0000_FF00, 32'h0000_FE00);
		dev_clk_pin <= 1'b0;
		dev_oe_n_pin <= 1'b1;
		st(6);
		`CHK("io_oe_n", 8'hFF, io_oe_n);
		$display("test registered done");
	endtask : t_reg

	task t_sec;
		wr(12'h010, 32'h1234_5678, 1'b0);
		wr(12'h014, 32'h9ABC_DEF0, 1'b0);
		wr(12'h004, 32'h0000_0009, 1'b0);
		rd(12'h008, 32'h0000_0001, 32'h0000_0001);
		drv_val <= 8'hA5;
		drv_en <= 8'hFF;
		st(6);
		wr(12'h004, 32'h0000_0003, 1'b0);
		st(2);
		rd(12'h008, 32'h0000_FF00, 32'h0000_5A00);
		drv_en <= 8'h00;
		dev_oe_n_pin <= 1'b0;
		st(6);
		`CHK("io_out", 8'hA5, io_out);
		wr(12'h004, 32'h0000_0000, 1'b0);
		rd(12'h100, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(12'h100, 32'h0000_0001, 1'b1);
		wr(12'h010, 32'h0000_0000, 1'b1);
		rd(12'h010, 32'hFFFF_FFFF, 32'h1234_5678);
		rd(12'h014, 32'hFFFF_FFFF, 32'h9ABC_DEF0);
		wr(12'h004, 32'h0000_0004, 1'b0);
		st(2);
		rd(12'h008, 32'h0000_0001, 32'h0000_0000);
		rd(12'h000, 32'hFFFF_FFFF, 32'h00FF_0001);
		rd(12'h120, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("test security done");
	endtask : t_sec

	task t_cio;
		wr(12'h000, 32'h00FF_FF02, 1'b0);
		wr(12'h15C, 32'h0000_0004, 1'b0);
		wr(12'h140, 32'h0000_0008, 1'b0);
		wr(12'h004, 32'h0000_0011, 1'b0);
		in_pin <= 8'h04;
		st(6);
		`CHK("io_oe_n", 8'hFB, io_oe_n);
		`CHK("io_out2", 1'b0, io_out[2]);
		in_pin <= 8'h0C;
		st(6);
		`CHK("io_out2", 1'b1, io_out[2]);
		in_pin <= 8'h00;
		st(6);
		`CHK("io_oe_n", 8'hFF, io_oe_n);
		$display("test comb io done");
	endtask : t_cio

	task t_din;
		wr(12'h004, 32'h0000_0000, 1'b0);
		wr(12'h000, 32'h00FF_0801, 1'b1);
		wr(12'h000, 32'h00FF_1001, 1'b1);
		wr(12'h000, 32'h00FF_0101, 1'b0);
		rd(12'h000, 32'hFFFF_FFFF, 32'h00FF_0101);
		wr(12'h004, 32'h0000_0001, 1'b0);
		st(6);
		`CHK("io_oe_n", 8'h01, io_oe_n);
		`CHK("io_out", 7'h7F, io_out[7:1]);
		$display("test input done");
	endtask : t_din

	task t_sby;
		wr(12'h004, 32'h0000_0000, 1'b0);
		wr(12'h120, 32'h0000_0001, 1'b0);
		wr(12'h004, 32'h0000_0011, 1'b0);
		sw;
		`CHK("standby", 1'b1, standby);
		`CHK("io_out", 7'h00, io_out[7:1]);
		in_pin <= 8'h01;
		st(6);
		`CHK("standby", 1'b0, standby);
		`CHK("io_out1", 1'b1, io_out[1]);
		wr(12'h004, 32'h0000_0031, 1'b0);
		sw;
		for (int i = 0; i < 3; i++) begin
			dev_clk_pin <= 1'b1;
			st(2);
			dev_clk_pin <= 1'b0;
			st(2);
			`CHK("standby", 1'b1, standby);
		end
		$display("test standby done");
	endtask : t_sby

	// ----------------------------------------
	// verdict
	// ----------------------------------------
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		mismatches++;
		report_and_stop;
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		dev_clk_pin = 1'b0;
		dev_oe_n_pin = 1'b0;
		in_pin = 8'h00;
		drv_val = 8'h00;
		drv_en = 8'h00;
		mismatches = 0;
		checks_done = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_pol;
		t_reg;
		t_sec;
		t_cio;
		t_din;
		t_sby;
		report_and_stop;
	end
endmodule : plm_macrocell_tb
